/* File: rtl/arsf_pkg.sv */
// constants for the converter result and status flag block
package arsf_pkg;
    localparam int ARSF_NCH = 4;
    localparam int ARSF_DW = 10;
    localparam int ARSF_AW = 4;
    localparam int ARSF_CW = 2;
    // register offsets (word addresses)
    localparam logic [ARSF_AW-1:0] ARSF_OFF_CTRL = 4'h0;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_MODE = 4'h1;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_CHEN = 4'h2;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_CHDIS = 4'h3;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_STATUS = 4'h4;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_LAST = 4'h5;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_IEN = 4'h6;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_ICLR = 4'h7;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_CHSR = 4'h8;
    localparam logic [ARSF_AW-1:0] ARSF_OFF_RES0 = 4'hc;
    // field positions
    localparam int ARSF_CTRL_START = 1;
    localparam int ARSF_MODE_SLEEP = 0;
    localparam int ARSF_ST_DONE = 0;
    localparam int ARSF_ST_OVR = 4;
    localparam int ARSF_ST_RDY = 8;
    localparam int ARSF_ST_GOVR = 9;
    localparam int ARSF_ST_SLEEP = 10;
    localparam int ARSF_EV_W = 3;
    localparam int ARSF_EV_RDY = 0;
    localparam int ARSF_EV_GOVR = 1;
    localparam int ARSF_EV_OVR = 2;
    localparam int ARSF_LAST_CH = 12;
    localparam logic [31:0] ARSF_ZERO = 32'h0000_0000;
endpackage

/* File: rtl/arsf_chan.sv */
// one channel's result holder and done/overrun flags
`timescale 1ns/1ps
`default_nettype none
module arsf_chan
    import arsf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // events
    input wire logic store_in,
    input wire logic [ARSF_DW-1:0] data_in,
    input wire logic read_in,
    input wire logic status_read_in,
    // state
    output logic done_out,
    output logic ovr_out,
    output logic [ARSF_DW-1:0] result_out
);
    logic ovr_clear;
    // overrun reset on status read ignores a coinciding done set
    assign ovr_clear = status_read_in && !done_out;

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            done_out <= 1'b0;
            ovr_out <= 1'b0;
            result_out <= '0;
        end else begin
            // set wins over clear of the same flag
            done_out <= store_in | (done_out & ~read_in);
            ovr_out <= (store_in & done_out) | (ovr_out & ~ovr_clear);
            if (store_in) begin
                result_out <= data_in;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/arsf_top.sv */
// status flags and result registers of the converter
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Data-ready clears only on last-result read, not per-channel reads.
// - Last-result read with end of disabled channel never sets data-ready.
// - Channel read during enabled channel's end still sets data-ready.
// - Disable coinciding with end stores result and raises data-ready.
// - Status read during end still clears or sets general overrun.
// - Channel read during end sets general overrun when data-ready pending.
// - Disable during end with flags set raises general and channel overrun.
// - Status read resets channel overrun once done cleared, despite new end.
// - Channel or last-result read clears that channel's done flag.
// - Disabled channel never raises done; software ignores disabled done flags.
// - Channel read clears only that channel's done flag.
// - Sleep picked while idle takes effect at end of next conversion.
module arsf_top
    import arsf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [ARSF_AW-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // conversion core
    input wire logic eoc_in,
    input wire logic [ARSF_CW-1:0] eoc_ch_in,
    input wire logic [ARSF_DW-1:0] eoc_data_in,
    input wire logic busy_in,
    output logic start_out,
    output logic [ARSF_NCH-1:0] chan_en_out,
    output logic sleep_out,
    // interrupt
    output logic irq_out
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic [ARSF_NCH-1:0] chen_reg, chen_next;
    logic mode_sleep_reg;
    logic sleep_reg;
    logic rdy_reg, govr_reg;
    logic [ARSF_CW-1:0] last_ch_reg;
    logic [ARSF_DW-1:0] last_reg;
    logic [ARSF_EV_W-1:0] ist_reg, ien_reg;
    logic start_reg;
    logic [31:0] rdata_reg;
    logic [ARSF_NCH-1:0] done, ovr, store, chan_rd;
    logic [ARSF_DW-1:0] res [ARSF_NCH];

    wire wr_ctrl = wr_in && addr_in == ARSF_OFF_CTRL;
    wire wr_mode = wr_in && addr_in == ARSF_OFF_MODE;
    wire wr_chen = wr_in && addr_in == ARSF_OFF_CHEN;
    wire wr_chdis = wr_in && addr_in == ARSF_OFF_CHDIS;
    wire wr_ien = wr_in && addr_in == ARSF_OFF_IEN;
    wire wr_iclr = wr_in && addr_in == ARSF_OFF_ICLR;
    wire rd_status = rd_in && addr_in == ARSF_OFF_STATUS;
    wire rd_last = rd_in && addr_in == ARSF_OFF_LAST;
    wire rd_chan = rd_in && addr_in[ARSF_AW-1:ARSF_CW] == ARSF_OFF_RES0[ARSF_AW-1:ARSF_CW];
    wire [ARSF_CW-1:0] rd_ch = addr_in[ARSF_CW-1:0];

    // ------------------------------------------------------------
    // channel enable
    // ------------------------------------------------------------
    // enable state takes effect next cycle; the end sample uses the old mask
    always_comb begin
        chen_next = chen_reg;
        if (wr_chen) begin
            chen_next = chen_next | wdata_in[ARSF_NCH-1:0];
        end
        if (wr_chdis) begin
            chen_next = chen_next & ~wdata_in[ARSF_NCH-1:0];
        end
    end

    // a disable coinciding with the end still lets the result land
    wire eoc_valid = eoc_in && chen_reg[eoc_ch_in];

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ARSF_NCH; g++) begin : g_ch
            assign store[g] = eoc_valid && eoc_ch_in == g;
            // only the addressed channel or the last stored one clears
            assign chan_rd[g] = (rd_chan && rd_ch == g) || (rd_last && last_ch_reg == g);
            arsf_chan u_ch (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .store_in(store[g]),
                .data_in(eoc_data_in),
                .read_in(chan_rd[g]),
                .status_read_in(rd_status),
                .done_out(done[g]),
                .ovr_out(ovr[g]),
                .result_out(res[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // data-ready and general overrun
    // ------------------------------------------------------------
    // per-channel reads leave data-ready alone
    wire rdy_next = eoc_valid | (rdy_reg & ~rd_last);
    // new overrun judged against the pending flag regardless of other reads
    wire govr_set = eoc_valid && rdy_reg;
    wire govr_next = govr_set | (govr_reg & ~rd_status);

    // ------------------------------------------------------------
    // sleep
    // ------------------------------------------------------------
    // sleep only lands at the end of a conversion; idle selection waits
    wire sleep_next = mode_sleep_reg ? (sleep_reg | (eoc_in & busy_in) | (sleep_reg & ~start_reg)) : 1'b0;

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    wire [ARSF_EV_W-1:0] ev = {|(store & done), govr_set, eoc_valid};
    wire [ARSF_EV_W-1:0] ist_next = ev | (ist_reg & ~({ARSF_EV_W{wr_iclr}} & wdata_in[ARSF_EV_W-1:0]));

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rmux;
    always_comb begin
        rmux = ARSF_ZERO;
        if (rd_chan) begin
            rmux[ARSF_DW-1:0] = res[rd_ch];
        end else begin
            case (addr_in)
                ARSF_OFF_MODE: rmux[ARSF_MODE_SLEEP] = mode_sleep_reg;
                ARSF_OFF_CHSR: rmux[ARSF_NCH-1:0] = chen_reg;
                ARSF_OFF_STATUS: begin
                    rmux[ARSF_ST_DONE +: ARSF_NCH] = done;
                    rmux[ARSF_ST_OVR +: ARSF_NCH] = ovr;
                    rmux[ARSF_ST_RDY] = rdy_reg;
                    rmux[ARSF_ST_GOVR] = govr_reg;
                    rmux[ARSF_ST_SLEEP] = sleep_reg;
                end
                ARSF_OFF_LAST: begin
                    rmux[ARSF_DW-1:0] = last_reg;
                    rmux[ARSF_LAST_CH +: ARSF_CW] = last_ch_reg;
                end
                ARSF_OFF_IEN: rmux[ARSF_EV_W-1:0] = ien_reg;
                ARSF_OFF_ICLR: rmux[ARSF_EV_W-1:0] = ist_reg;
                default: rmux = ARSF_ZERO;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            chen_reg <= '0;
            mode_sleep_reg <= 1'b0;
            sleep_reg <= 1'b0;
            rdy_reg <= 1'b0;
            govr_reg <= 1'b0;
            last_ch_reg <= '0;
            last_reg <= '0;
            ist_reg <= '0;
            ien_reg <= '0;
            start_reg <= 1'b0;
            rdata_reg <= ARSF_ZERO;
            irq_out <= 1'b0;
        end else begin
            chen_reg <= chen_next;
            rdy_reg <= rdy_next;
            govr_reg <= govr_next;
            sleep_reg <= sleep_next;
            ist_reg <= ist_next;
            irq_out <= |(ist_next & ien_reg);
            start_reg <= wr_ctrl && wdata_in[ARSF_CTRL_START];
            rdata_reg <= rd_in ? rmux : ARSF_ZERO;
            if (wr_mode) begin
                mode_sleep_reg <= wdata_in[ARSF_MODE_SLEEP];
            end
            if (wr_ien) begin
                ien_reg <= wdata_in[ARSF_EV_W-1:0];
            end
            if (eoc_valid) begin
                last_reg <= eoc_data_in;
                last_ch_reg <= eoc_ch_in;
            end
        end
    end

    assign rdata_out = rdata_reg;
    assign start_out = start_reg;
    assign chan_en_out = chen_reg;
    assign sleep_out = sleep_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_end_enabled;
        eoc_in && chen_reg[eoc_ch_in];
    endsequence

    AST_RDY_CHREAD_KEEP: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        rdy_reg && !rd_last |=> rdy_reg) else $error("data-ready lost without last read");
    AST_RDY_DISABLED_END: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !rdy_reg && eoc_in && !chen_reg[eoc_ch_in] |=> !rdy_reg) else $error("data-ready from disabled end");
    AST_RDY_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_end_enabled |=> rdy_reg) else $error("data-ready skipped");
    AST_LAST_STORE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_end_enabled ##0 wr_chdis |=> last_reg == $past(eoc_data_in)) else $error("result not stored");
    AST_GOVR_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        rd_status && !rdy_reg |=> !govr_reg) else $error("general overrun not cleared");
    AST_GOVR_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_end_enabled ##0 rdy_reg |=> govr_reg) else $error("general overrun not set");
    AST_OVR_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        s_end_enabled ##0 done[eoc_ch_in] |=> ovr[$past(eoc_ch_in)]) else $error("channel overrun not set");
    AST_DONE_DISABLED: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        eoc_in && !chen_reg[eoc_ch_in] && !done[eoc_ch_in] |=> !done[$past(eoc_ch_in)])
        else $error("done raised on disabled channel");
    AST_SLEEP_WAITS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !sleep_reg && !eoc_in |=> !sleep_reg) else $error("sleep without conversion end");
endmodule
`default_nettype wire

/* File: tb/arsf_core_model.sv */
// behavioural conversion core, ends of conversion fired on bench command
`timescale 1ns/1ps
`default_nettype none
module arsf_core_model
    import arsf_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // bench control
    input wire logic go_in,
    input wire logic [ARSF_CW-1:0] go_ch_in,
    // converter side
    input wire logic start_in,
    output logic eoc_out,
    output logic [ARSF_CW-1:0] eoc_ch_out,
    output logic [ARSF_DW-1:0] eoc_data_out,
    output logic busy_out
);
    logic busy_reg;
    logic [ARSF_DW-1:0] val_w;
    // data carry the channel number; inverted outside a pulse so stale data never look valid
    assign val_w = {go_ch_in, 8'h3c};
    assign eoc_out = go_in;
    assign eoc_ch_out = go_ch_in;
    assign eoc_data_out = go_in ? val_w : ~val_w;
    assign busy_out = busy_reg;
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_reg <= 1'b0;
        end else if (start_in) begin
            busy_reg <= 1'b1;
        end else if (go_in) begin
            busy_reg <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: tb/tb_arsf_top.sv */
// self-checking bench for the converter status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_arsf_top;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0, go = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0, rdata_out;
    logic [1:0] go_ch = 2'h0, eoc_ch;
    logic [9:0] eoc_data;
    logic [3:0] chan_en;
    logic eoc, busy, start, sleep, irq;
    int bad_count = 0, check_count = 0, cyc_count = 0;
    always #12.5 ref_clk_in = ~ref_clk_in;
    arsf_top dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .eoc_in(eoc), .eoc_ch_in(eoc_ch),
        .eoc_data_in(eoc_data), .busy_in(busy), .start_out(start), .chan_en_out(chan_en),
        .sleep_out(sleep), .irq_out(irq));
    arsf_core_model core (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .go_in(go), .go_ch_in(go_ch),
        .start_in(start), .eoc_out(eoc), .eoc_ch_out(eoc_ch), .eoc_data_out(eoc_data), .busy_out(busy));
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, x);
        end
    endtask
    // one bus cycle, optionally coinciding with an end of conversion
    task automatic cyc(input logic w, r, input logic [3:0] a, input logic [31:0] d, input logic e,
        input logic [1:0] c);
        wr_in <= w;
        rd_in <= r;
        addr_in <= a;
        wdata_in <= d;
        go <= e;
        go_ch <= c;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        rd_in <= 1'b0;
        go <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic e = 0,
        input logic [1:0] c = 0, input logic [31:0] m = 32'hffff_ffff);
        cyc(1'b0, 1'b1, a, 32'h0, e, c);
        chk(rdata_out & m, x);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic e = 0, input logic [1:0] c = 0);
        cyc(1'b1, 1'b0, a, d, e, c);
    endtask
    task automatic ev(input logic [1:0] c);
        cyc(1'b0, 1'b0, 4'h0, 32'h0, 1'b1, c);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_ready();
        rd(4'h4, 32'h0);
        wr(4'h2, 32'hf);
        ev(2'd0);
        rd(4'h4, 32'h101);
        rd(4'h5, 32'h003c);
        rd(4'h4, 32'h0);
        ev(2'd1);
        rd(4'hc, 32'h03c, 1'b1, 2'd1);
        rd(4'h4, 32'h322);
        rd(4'h4, 32'h122);
    endtask
    task automatic t_overrun();
        rd(4'h4, 32'h122, 1'b1, 2'd2);
        rd(4'h4, 32'h326);
        rd(4'h5, 32'h223c);
        rd(4'h4, 32'h022, 1'b1, 2'd3);
        rd(4'h4, 32'h12a);
        rd(4'hd, 32'h13c);
        rd(4'h4, 32'h128, 1'b1, 2'd1);
        rd(4'h4, 32'h30a);
        rd(4'hf, 32'h33c, 1'b1, 2'd0);
        rd(4'h4, 32'h303);
    endtask
    task automatic t_disable();
        wr(4'h3, 32'h4, 1'b1, 2'd0);
        rd(4'h8, 32'hb);
        rd(4'h4, 32'h313);
        rd(4'h5, 32'h03c, 1'b1, 2'd2);
        rd(4'h4, 32'h012, 1'b0, 2'd0, 32'h1ff);
        rd(4'he, 32'h23c);
    endtask
    task automatic t_irq();
        wr(4'h7, 32'h7);
        rd(4'h7, 32'h0);
        ev(2'd3);
        rd(4'h7, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(4'h6, 32'h1);
        rd(4'h9, 32'h0);
        chk({31'h0, irq}, 32'h1);
        wr(4'h7, 32'h1);
        rd(4'h7, 32'h0);
        chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_sleep();
        // sleep first, then start, so power-down follows the started conversion
        wr(4'h1, 32'h1);
        rd(4'h4, 32'h0, 1'b0, 2'd0, 32'h400);
        chk({31'h0, sleep}, 32'h0);
        wr(4'h0, 32'h2);
        rd(4'h9, 32'h0);
        ev(2'd0);
        rd(4'h4, 32'h400, 1'b0, 2'd0, 32'h400);
        chk({31'h0, sleep}, 32'h1);
    endtask
    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        cyc_count++;
        if (cyc_count == 2000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        t_ready();
        t_overrun();
        t_disable();
        t_irq();
        t_sleep();
        summarize();
    end
endmodule
`default_nettype wire
